/* rtl/ccp_pkg.sv */
// Purpose: Constants and types for the cascaded convolution host controller.
// Assumes: Devices take 16-bit words at small word addresses; Wishbone byte addresses.
// Notes:   Summary of operation
// Summary of operation
// - Non-final row devices use direct shift-chain route
// - Final row device forwards via indirect route
// - Alignment delay three above the following device
// - Later-row first alignment: 7M plus L minus 20
// - First-row right-most alignment free, deskew value
// - Every programmed delay must fit the lines
// - Two-D row delays equal line plus seven
// - Eight-bit result slice feeds second device
// - Two-device passes programmed as stand-alone filters
// - Feed back alternate results, swap banks, half rate
// - Feedback mode row delays twice line plus seven
// - Own bank per pass, odd coefficients zero
// - Split 16-bit samples into two byte streams
// - Low device unsigned, high follows input signedness
// - Adder sums upper 14 low bits with high
// - Append low eight bits beneath the sum
// - Select 16-bit slice for next precision stage
package ccp_pkg;
  // Wishbone register byte offsets
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_GEOM   = 8'h04;
  localparam logic [7:0]  ADR_SLICE  = 8'h08;
  localparam logic [7:0]  ADR_STATUS = 8'h0C;
  localparam logic [7:0]  ADR_RAW    = 8'h10;
  // Field positions
  localparam int CTRL_START  = 0;  // Write 1 to program all devices
  localparam int CTRL_RUN    = 1;  // Stream enable
  localparam int CTRL_MODE   = 2;  // Two-bit cascade mode
  localparam int CTRL_SIGNED = 4;  // Signed input samples
  localparam int CTRL_SCR    = 8;  // Eight-bit setup register base
  localparam int CTRL_BASE   = 16; // Eleven-bit deskew alignment
  localparam int GEOM_COLS   = 16; // Devices per row, four bits
  localparam int GEOM_ROWS   = 20; // Rows, four bits
  localparam int SLICE_SH8   = 8;  // Shift for eight-bit slice
  localparam int STAT_BUSY   = 0;
  localparam int STAT_ERR    = 1;
  localparam int STAT_DONE   = 2;
  localparam int STAT_LEVEL  = 8;
  localparam int RAW_ADR     = 16;
  localparam int RAW_DEV     = 24;
  // Widths
  localparam int LINE_W = 11;
  localparam int DLY_W  = 17;
  localparam int PIX_W  = 8;
  localparam int SMP_W  = 16;
  localparam int PART_W = 22;
  localparam int LOW_W  = 8;
  localparam int RES_W  = PART_W + LOW_W;
  localparam int SH_W   = 5;
  // Device side addresses and setup bits
  localparam logic [7:0] DEV_SCR     = 8'h00;
  localparam logic [7:0] DEV_ROW_A   = 8'h01;
  localparam logic [7:0] DEV_ROW_B   = 8'h02;
  localparam logic [7:0] DEV_ALIGN   = 8'h03;
  localparam logic [7:0] DEV_COEF    = 8'h10;  // Coefficient area start
  localparam int         SCR_ROUTE   = 0;      // Set: indirect route
  localparam int         SCR_SIGNED  = 2;      // Set: signed data
  // Delay arithmetic
  localparam int ROW_EXTRA  = 7;
  localparam int ALIGN_STEP = 3;
  localparam int FIRST_MUL  = 7;
  localparam int FIRST_SUB  = 20;
  localparam int MAX_DELAY  = 1120;
  localparam int SAMPLE_DIV = 4;   // Clocks per pixel sample
  // Reset values
  localparam logic [3:0] RST_COLS = 4'h1;
  localparam logic [3:0] RST_ROWS = 4'h1;
  // Cascade modes as held in the control register
  localparam logic [1:0] MODE_GRID = 2'h0;
  localparam logic [1:0] MODE_PASS = 2'h1;
  localparam logic [1:0] MODE_FBK  = 2'h2;
  localparam logic [1:0] MODE_PREC = 2'h3;
  // Sequencer states
  typedef enum logic [1:0] { ST_IDLE, ST_PROG, ST_GAP } ccp_state_t;
endpackage : ccp_pkg

/* rtl/ccp_fifo.sv */
// Purpose: Sample FIFO with valid and ready on both sides.
// Assumes: Single clock, flip-flop storage.
// Notes:   Ready is registered so the top can drive it straight from a flop.
`timescale 1ns/10ps
module ccp_fifo
  import ccp_pkg::*;
#(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                   clk_i,       // System clock
  input  wire logic                   sys_rst_i,   // Async reset, high
  input  wire logic                   in_valid_i,  // Write request
  input  wire logic [W-1:0]           in_data_i,   // Write word
  output logic                        in_ready_o,  // Space available
  output logic                        out_valid_o, // Word available
  output logic [W-1:0]                out_data_i_o,// Head word
  input  wire logic                   out_ready_i, // Drain request
  output logic [$clog2(D):0]          level_o      // Words held
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage
    logic [AW-1:0]       wp;    // Write index
    logic [AW-1:0]       rp;    // Read index
    logic [AW:0]         cnt;   // Occupancy
    logic                rdy;   // Registered not-full
  } ccp_fifo_t;
  ccp_fifo_t r_reg, r_next;
  logic push, pop;

  // Pointer and occupancy update; a pop frees room from the next cycle on, as ready is registered
  always_comb begin
    r_next = r_reg;
    push   = in_valid_i & r_reg.rdy;
    pop    = out_ready_i & (r_reg.cnt != '0);
    if (push) begin
      r_next.mem[r_reg.wp] = in_data_i;
      r_next.wp            = AW'(r_reg.wp + 1'b1);
    end
    if (pop) begin
      r_next.rp = AW'(r_reg.rp + 1'b1);
    end
    r_next.cnt = (AW+1)'(r_reg.cnt + {AW'(0), push} - {AW'(0), pop});
    r_next.rdy = (r_next.cnt < (AW+1)'(D));
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_reg     <= '0;
      r_reg.rdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready_o   = r_reg.rdy;
  assign out_valid_o  = (r_reg.cnt != '0);
  assign out_data_i_o = r_reg.mem[r_reg.rp];
  assign level_o      = r_reg.cnt;
endmodule // ccp_fifo

/* rtl/ccp_combine.sv */
// Purpose: Joins two 22-bit partial results into one 30-bit filtered value.
// Assumes: Both partial results are aligned and valid in the same cycle.
// Notes:   Low partial result is sign extended; its device may still yield negatives.
`timescale 1ns/10ps
module ccp_combine
  import ccp_pkg::*;
(
  input  wire logic              clk_i,       // System clock
  input  wire logic              sys_rst_i,   // Async reset, high
  input  wire logic [PART_W-1:0] cas_lo_i,    // Low-byte device result
  input  wire logic [PART_W-1:0] cas_hi_i,    // High-byte device result
  input  wire logic              cas_valid_i, // Results valid
  input  wire logic [SH_W-1:0]   sh16_i,      // Slice shift
  output logic [RES_W-1:0]       res_o,       // Full result
  output logic                   res_valid_o, // Result valid pulse
  output logic [SMP_W-1:0]       slice_o      // Slice for next stage
);
  typedef struct packed {
    logic [RES_W-1:0] res;   // Combined result
    logic             vld;   // Valid pulse
    logic [SMP_W-1:0] slc;   // Chained slice
  } ccp_comb_t;
  ccp_comb_t        r_reg, r_next;
  logic [PART_W-1:0] upper;
  logic [RES_W-1:0]  full;

  // Sum, append and slice all land in one register stage
  always_comb begin
    r_next = r_reg;
    upper  = PART_W'(cas_hi_i + {{LOW_W{cas_lo_i[PART_W-1]}}, cas_lo_i[PART_W-1:LOW_W]});
    full   = {upper, cas_lo_i[LOW_W-1:0]};
    r_next.vld = cas_valid_i;
    if (cas_valid_i) begin
      r_next.res = full;
      r_next.slc = SMP_W'(full >> sh16_i);
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign res_o       = r_reg.res;
  assign res_valid_o = r_reg.vld;
  assign slice_o     = r_reg.slc;
endmodule // ccp_combine

/* rtl/ccp_host.sv */
// Purpose: Host controller that programs a cascade of convolution devices and feeds pixels.
// Assumes: Devices take one word per dev_wr_o pulse; results return aligned on cas_valid_i.
// Notes:   Pixel rate is one clock enable every SAMPLE_DIV clocks; feedback halves input rate.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
module ccp_host
  import ccp_pkg::*;
#(
  parameter int FIFO_D  = 16,        // Sample FIFO depth
  parameter int MAXDLY  = MAX_DELAY, // Longest delay line
  parameter int DIV     = SAMPLE_DIV // Clocks per pixel
) (
  input  wire logic              clk_i,       // System clock, 125 MHz
  input  wire logic              sys_rst_i,   // Async reset, high
  input  wire logic              wb_cyc_i,    // Wishbone cycle
  input  wire logic              wb_stb_i,    // Wishbone strobe
  input  wire logic              wb_we_i,     // Wishbone write
  input  wire logic [7:0]        wb_adr_i,    // Byte address
  input  wire logic [31:0]       wb_dat_i,    // Write data
  input  wire logic [3:0]        wb_sel_i,    // Byte lanes
  output logic [31:0]            wb_dat_o,    // Read data
  output logic                   wb_ack_o,    // Acknowledge
  output logic [7:0]             dev_sel_o,   // Target device index
  output logic [7:0]             dev_adr_o,   // Device register address
  output logic [15:0]            dev_dat_o,   // Device write word
  output logic                   dev_wr_o,    // Device write pulse
  input  wire logic              smp_valid_i, // Sample offered
  input  wire logic [SMP_W-1:0]  smp_data_i,  // 16-bit sample
  output logic                   smp_ready_o, // Sample accepted
  output logic [PIX_W-1:0]       pix_lo_o,    // First device input
  output logic [PIX_W-1:0]       pix_hi_o,    // Second device input
  output logic                   pix_stb_o,   // Pixel enable pulse
  output logic                   bank_o,      // Coefficient bank select
  input  wire logic [PART_W-1:0] cas_lo_i,    // First device result
  input  wire logic [PART_W-1:0] cas_hi_i,    // Second device result
  input  wire logic              cas_valid_i, // Results valid
  output logic [RES_W-1:0]       res_o,       // Combined result
  output logic                   res_valid_o, // Result valid pulse
  output logic [SMP_W-1:0]       slice_o      // Chained 16-bit slice
);
  localparam int LVL_W = $clog2(FIFO_D) + 1;
  localparam int DIV_W = 8;

  typedef struct packed {
    ccp_state_t        st;      // Sequencer state
    logic [1:0]        mode;    // Cascade mode
    logic              sgn;     // Signed samples
    logic              run;     // Streaming on
    logic [7:0]        setup_control_register;     // Setup register base
    logic [LINE_W-1:0] base;    // Deskew alignment
    logic [LINE_W-1:0] line;    // Line length
    logic [3:0]        cols;    // Devices per row
    logic [3:0]        rows;    // Row count
    logic [SH_W-1:0]   sh16;    // Wide slice shift
    logic [SH_W-1:0]   sh8;     // Narrow slice shift
    logic              done;    // Programming finished, sticky
    logic              err;     // Range error, sticky
    logic [3:0]        col;     // Current column
    logic [3:0]        row;     // Current row
    logic [1:0]        item;    // Word within device
    logic [7:0]        dev;     // Current device
    logic              fin;     // Last word issued
    logic [7:0]        dsel;    // Device select out
    logic [7:0]        dadr;    // Device address out
    logic [15:0]       ddat;    // Device data out
    logic              dwr;     // Device write out
    logic              ack;     // Bus acknowledge
    logic [31:0]       rdat;    // Bus read data
    logic [DIV_W-1:0]  div;     // Pixel divider
    logic              tick;    // Pixel enable
    logic              phase;   // Feedback slot
    logic [PIX_W-1:0]  plo;     // Pixel low out
    logic [PIX_W-1:0]  phi;     // Pixel high out
    logic              pstb;    // Pixel strobe out
    logic              bank;    // Bank out
    logic              rdy;     // Registered FIFO ready, not driven out
  } ccp_host_t;

  ccp_host_t r_reg, r_next;

  logic                fifo_rdy, fifo_vld, fifo_pop;
  logic [SMP_W-1:0]    fifo_dat;
  logic [LVL_W-1:0]    fifo_lvl;
  logic [SMP_W-1:0]    res_slice;

  // Sample buffer between the sample port and the pixel pacer
  ccp_fifo #(.W(SMP_W), .D(FIFO_D)) u_fifo (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .in_valid_i   (smp_valid_i),
    .in_data_i    (smp_data_i),
    .in_ready_o   (fifo_rdy),
    .out_valid_o  (fifo_vld),
    .out_data_i_o (fifo_dat),
    .out_ready_i  (fifo_pop),
    .level_o      (fifo_lvl)
  );

  // Partial result combiner for the precision cascade
  ccp_combine u_comb (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .cas_lo_i    (cas_lo_i),
    .cas_hi_i    (cas_hi_i),
    .cas_valid_i (cas_valid_i),
    .sh16_i      (r_reg.sh16),
    .res_o       (res_o),
    .res_valid_o (res_valid_o),
    .slice_o     (res_slice)
  );

  // Pops only on a pixel slot; the feedback slot leaves the FIFO alone
  assign fifo_pop = r_reg.tick & r_reg.run & (r_reg.st == ST_IDLE)
                  & ~((r_reg.mode == MODE_FBK) & r_reg.phase);

  // Locals of the next-state process
  logic              acc, wr, start;
  logic [31:0]       mask, ctrl_w, geom_w, slice_w;
  logic [7:0]        ndev;
  logic              last_col;
  logic signed [DLY_W-1:0] l_s, m_s, c_s, b_s, row_v, aln_v, val;
  logic [7:0]        scr_v, dadr_v;
  logic [PART_W-1:0] fb_sh;
  logic [7:0]        fb8;

  // Next-state process: bus slave, programming sequencer, pixel pacer
  always_comb begin
    r_next    = r_reg;
    r_next.dwr  = 1'b0;
    r_next.pstb = 1'b0;
    r_next.tick = 1'b0;
    acc   = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    wr    = acc & wb_we_i;
    mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    ctrl_w  = {5'h00, r_reg.base, r_reg.setup_control_register, 3'h0, r_reg.sgn, r_reg.mode, r_reg.run, 1'b0};
    geom_w  = {8'h00, r_reg.rows, r_reg.cols, 5'h00, r_reg.line};
    slice_w = {19'h00000, r_reg.sh8, 3'h0, r_reg.sh16};
    ctrl_w  = (ctrl_w & ~mask) | (wb_dat_i & mask);
    geom_w  = (geom_w & ~mask) | (wb_dat_i & mask);
    slice_w = (slice_w & ~mask) | (wb_dat_i & mask);
    start = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START]
          & (r_reg.st == ST_IDLE);
    // Single-cycle answer: ack one clock after the request, then drops
    r_next.ack = acc;
    if (acc & ~wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL:   r_next.rdat = {ctrl_w[31:1] & 31'h0, 1'b0}
                                | {5'h00, r_reg.base, r_reg.setup_control_register, 3'h0, r_reg.sgn,
                                   r_reg.mode, r_reg.run, 1'b0};
        ADR_GEOM:   r_next.rdat = {8'h00, r_reg.rows, r_reg.cols, 5'h00, r_reg.line};
        ADR_SLICE:  r_next.rdat = {19'h00000, r_reg.sh8, 3'h0, r_reg.sh16};
        ADR_STATUS: r_next.rdat = {16'h0000, 8'(fifo_lvl), 5'h00, r_reg.done, r_reg.err,
                                   (r_reg.st != ST_IDLE)};
        default:    r_next.rdat = 32'h00000000; // Unmapped and write-only read zero
      endcase
    end
    // Register writes; configuration is frozen while programming
    if (wr & (r_reg.st == ST_IDLE)) begin
      unique case (wb_adr_i)
        ADR_CTRL: begin
          r_next.run  = ctrl_w[CTRL_RUN];
          r_next.mode = ctrl_w[CTRL_MODE +: 2];
          r_next.sgn  = ctrl_w[CTRL_SIGNED];
          r_next.setup_control_register  = ctrl_w[CTRL_SCR +: 8];
          r_next.base = ctrl_w[CTRL_BASE +: LINE_W];
        end
        ADR_GEOM: begin
          r_next.line = geom_w[LINE_W-1:0];
          r_next.cols = geom_w[GEOM_COLS +: 4];
          r_next.rows = geom_w[GEOM_ROWS +: 4];
        end
        ADR_SLICE: begin
          r_next.sh16 = slice_w[SH_W-1:0];
          r_next.sh8  = slice_w[SLICE_SH8 +: SH_W];
        end
        default: begin
        end
      endcase
    end
    // Write one to clear; hardware sets below take precedence
    if (wr & (wb_adr_i == ADR_STATUS) & wb_sel_i[0]) begin
      if (wb_dat_i[STAT_DONE]) r_next.done = 1'b0;
      if (wb_dat_i[STAT_ERR])  r_next.err  = 1'b0;
    end

    // Delay arithmetic for the device under programming
    ndev = (r_reg.mode == MODE_GRID) ? 8'(r_reg.cols * r_reg.rows)
         : (r_reg.mode == MODE_FBK)  ? 8'h01 : 8'h02;
    last_col = (r_reg.col == 4'(r_reg.cols - 1'b1));
    l_s = DLY_W'(r_reg.line);
    m_s = DLY_W'(r_reg.cols);
    c_s = DLY_W'(r_reg.col);
    b_s = DLY_W'(r_reg.base);
    if (r_reg.mode == MODE_FBK) begin
      row_v = DLY_W'(2 * l_s + ROW_EXTRA);
    end else begin
      row_v = DLY_W'(l_s + ROW_EXTRA);
    end
    if ((r_reg.mode == MODE_GRID) && (r_reg.row != 4'h0)) begin
      aln_v = DLY_W'(FIRST_MUL * m_s + l_s - FIRST_SUB - ALIGN_STEP * c_s);
    end else if (r_reg.mode == MODE_GRID) begin
      aln_v = DLY_W'(b_s + ALIGN_STEP * (m_s - 1 - c_s));
    end else begin
      aln_v = b_s;
    end
    // Setup word: route and signedness per device position
    scr_v = r_reg.setup_control_register;
    scr_v[SCR_ROUTE]  = (r_reg.mode != MODE_GRID) | last_col;
    if (r_reg.mode == MODE_PREC) begin
      scr_v[SCR_SIGNED] = r_reg.sgn & (r_reg.dev == 8'h01);
    end else begin
      scr_v[SCR_SIGNED] = r_reg.sgn;
    end
    unique case (r_reg.item)
      2'h0:    begin dadr_v = DEV_SCR;   val = DLY_W'(scr_v); end
      2'h1:    begin dadr_v = DEV_ROW_A; val = row_v;         end
      2'h2:    begin dadr_v = DEV_ROW_B; val = row_v;         end
      default: begin dadr_v = DEV_ALIGN; val = aln_v;         end
    endcase

    // Programming sequencer
    unique case (r_reg.st)
      ST_IDLE: begin
        if (start) begin
          r_next.col  = 4'h0;
          r_next.row  = 4'h0;
          r_next.item = 2'h0;
          r_next.dev  = 8'h00;
          r_next.fin  = 1'b0;
          r_next.run  = 1'b0;
          // Judge the mode being written now, not the one it replaces
          if ((ctrl_w[CTRL_MODE +: 2] == MODE_GRID)
              && (8'(r_reg.cols * r_reg.rows) == 8'h00)) begin
            r_next.err = 1'b1;
          end else begin
            r_next.st  = ST_PROG;
            r_next.done = 1'b0;
          end
        end else if (wr & (wb_adr_i == ADR_RAW)) begin
          // Raw device write, used for coefficient banks
          r_next.dsel = wb_dat_i[RAW_DEV +: 8];
          r_next.dadr = wb_dat_i[RAW_ADR +: 8];
          r_next.ddat = wb_dat_i[15:0];
          r_next.dwr  = 1'b1;
          if ((r_reg.mode == MODE_FBK) && (wb_dat_i[RAW_ADR +: 8] >= DEV_COEF)
              && wb_dat_i[RAW_ADR]) begin
            r_next.ddat = 16'h0000;
          end
        end
      end
      ST_PROG: begin
        if ((val < 0) || (val > DLY_W'(MAXDLY))) begin
          r_next.err = 1'b1;
          r_next.st  = ST_IDLE;
        end else begin
          r_next.dsel = r_reg.dev;
          r_next.dadr = dadr_v;
          r_next.ddat = 16'(val);
          r_next.dwr  = 1'b1;
          r_next.st   = ST_GAP;
          r_next.item = 2'(r_reg.item + 1'b1);
          if (r_reg.item == 2'h3) begin
            r_next.fin = (r_reg.dev == 8'(ndev - 1'b1));
            r_next.dev = 8'(r_reg.dev + 1'b1);
            r_next.col = last_col ? 4'h0 : 4'(r_reg.col + 1'b1);
            r_next.row = last_col ? 4'(r_reg.row + 1'b1) : r_reg.row;
          end
        end
      end
      ST_GAP: begin
        // One idle clock between device writes
        r_next.st = r_reg.fin ? ST_IDLE : ST_PROG;
        if (r_reg.fin) r_next.done = 1'b1;
      end
    endcase

    // Pixel divider and pacer
    if (r_reg.div == DIV_W'(DIV - 1)) begin
      r_next.div  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.div = DIV_W'(r_reg.div + 1'b1);
    end
    fb_sh = cas_lo_i >> r_reg.sh8;
    fb8   = fb_sh[PIX_W-1:0];
    if (r_reg.tick & r_reg.run & (r_reg.st == ST_IDLE)) begin
      if ((r_reg.mode == MODE_FBK) && r_reg.phase) begin
        r_next.plo   = fb8;
        r_next.pstb  = 1'b1;
        r_next.phase = 1'b0;
        r_next.bank  = 1'b1;
      end else if (fifo_vld) begin
        r_next.plo   = fifo_dat[PIX_W-1:0];
        r_next.phi   = (r_reg.mode == MODE_PASS) ? fb8 : fifo_dat[SMP_W-1:PIX_W];
        r_next.pstb  = 1'b1;
        r_next.phase = (r_reg.mode == MODE_FBK);
        r_next.bank  = 1'b0;
      end
    end
    r_next.rdy = fifo_rdy;
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_reg      <= '0;
      r_reg.st   <= ST_IDLE;
      r_reg.cols <= RST_COLS;
      r_reg.rows <= RST_ROWS;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o    = r_reg.rdat;
  assign wb_ack_o    = r_reg.ack;
  assign dev_sel_o   = r_reg.dsel;
  assign dev_adr_o   = r_reg.dadr;
  assign dev_dat_o   = r_reg.ddat;
  assign dev_wr_o    = r_reg.dwr;
  assign smp_ready_o = fifo_rdy;
  assign pix_lo_o    = r_reg.plo;
  assign pix_hi_o    = r_reg.phi;
  assign pix_stb_o   = r_reg.pstb;
  assign bank_o      = r_reg.bank;
  assign slice_o     = res_slice;
endmodule // ccp_host

/* bench/ccp_host_properties.sv */
// Purpose: Port assertions for the cascade host controller.
// Assumes: One clock, reset async high.
// Notes:   Bound at the foot of this file.
`timescale 1ns/10ps
module ccp_host_props
  import ccp_pkg::*;
(
  input wire logic              clk_i,       // Clock
  input wire logic              sys_rst_i,   // Reset
  input wire logic              wb_cyc_i,    // Cycle
  input wire logic              wb_ack_o,    // Ack
  input wire logic              dev_wr_o,    // Write
  input wire logic [7:0]        dev_adr_o,   // Address
  input wire logic [15:0]       dev_dat_o,   // Word
  input wire logic [PART_W-1:0] cas_lo_i,    // Low
  input wire logic [PART_W-1:0] cas_hi_i,    // High
  input wire logic              cas_valid_i, // Valid
  input wire logic [RES_W-1:0]  res_o,       // Result
  input wire logic              res_valid_o  // Valid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Both row lines always get the same length, two clocks apart
  sequence row_a_s; dev_wr_o && dev_adr_o == DEV_ROW_A; endsequence
  sequence row_b_s; ##2 dev_wr_o && dev_adr_o == DEV_ROW_B && dev_dat_o == $past(dev_dat_o, 2);
  endsequence
  ack_due_a: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  row_pair_a: assert property (row_a_s |-> row_b_s) else $error("rows");
  dly_fit_a: assert property (dev_wr_o && dev_adr_o inside {[DEV_ROW_A:DEV_ALIGN]} |->
    dev_dat_o <= 16'(MAX_DELAY)) else $error("delay");
  wr_gap_a: assert property (dev_wr_o |=> !dev_wr_o) else $error("wr gap");
  dev_hold_a: assert property (!dev_wr_o |-> $stable(dev_dat_o)) else $error("hold");
  res_sum_a: assert property (cas_valid_i |=> res_valid_o && res_o == {$past(cas_hi_i)
    + {{8{$past(cas_lo_i[21])}}, $past(cas_lo_i[21:8])}, $past(cas_lo_i[7:0])}) else $error("sum");
  res_idle_a: assert property (!cas_valid_i |=> !res_valid_o) else $error("res");
endmodule // ccp_host_props
bind ccp_host ccp_host_props ccp_host_props_i (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_ack_o,
  .dev_wr_o, .dev_adr_o, .dev_dat_o, .cas_lo_i, .cas_hi_i, .cas_valid_i, .res_o, .res_valid_o);

/* bench/ccp_dev.sv */
// Purpose: Behavioural model of the filter devices.
// Assumes: Setup words at addresses 0 to 3.
// Notes:   Coefficients are dropped; results map pixels.
`timescale 1ns/10ps
module ccp_dev
  import ccp_pkg::*;
(
  input  wire logic [0:0]  clk_i,       // Clock
  input  wire logic [0:0]  sys_rst_i,   // Reset
  input  wire logic [7:0]  dev_sel_i,   // Device
  input  wire logic [7:0]  dev_adr_i,   // Address
  input  wire logic [15:0] dev_dat_i,   // Word
  input  wire logic [0:0]  dev_wr_i,    // Write
  input  wire logic [7:0]  pix_lo_i,    // Low byte
  input  wire logic [7:0]  pix_hi_i,    // High byte
  input  wire logic [0:0]  pix_stb_i,   // Pixel
  output logic [21:0]      cas_lo_o,    // Low part
  output logic [21:0]      cas_hi_o,    // High part
  output logic             cas_valid_o  // Valid
);
  logic [15:0] regs [8][4]; // Setup words
  // Keep setup words only; coefficient area is accepted blindly
  always_ff @(posedge clk_i) begin
    if (dev_wr_i && dev_adr_i < 8'h04) regs[dev_sel_i[2:0]][dev_adr_i[1:0]] <= dev_dat_i;
  end
  // One clock from pixel to partial results
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cas_valid_o <= 1'b0;
      cas_lo_o    <= 22'h000000;
      cas_hi_o    <= 22'h000000;
    end else begin
      cas_valid_o <= pix_stb_i;
      cas_lo_o    <= {6'h00, pix_hi_i, pix_lo_i};
      cas_hi_o    <= {14'h0000, pix_hi_i};
    end
  end
endmodule // ccp_dev

/* bench/ccp_host_bench.sv */
// Purpose: Self-checking bench for the cascade host controller.
// Assumes: Device model answers one clock after each pixel.
// Notes:   Only byte lanes, the strobe (to the cycle line) and the sample word are tied.
`timescale 1ns/10ps
module ccp_host_bench
  import ccp_pkg::*;
;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0, smp_valid_i = 1'b0;
  logic wb_ack_o, dev_wr_o, smp_ready_o, pix_stb_o, cas_valid_i, res_valid_o, bnk;
  logic [7:0] wb_adr_i = 8'h00, dev_sel_o, dev_adr_o, pix_lo_o, pix_hi_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] dev_dat_o, slc;
  logic [PART_W-1:0] cas_lo_i, cas_hi_i;
  logic [RES_W-1:0] res_o;
  int fail_count = 0, n_checks = 0, n;
  initial forever #4 clk_i = ~clk_i;
  ccp_host ccp_host_i (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .dev_sel_o, .dev_adr_o, .dev_dat_o,
    .dev_wr_o, .smp_valid_i, .smp_data_i(16'h1234), .smp_ready_o, .pix_lo_o, .pix_hi_o,
    .pix_stb_o, .bank_o(bnk), .cas_lo_i, .cas_hi_i, .cas_valid_i, .res_o, .res_valid_o,
    .slice_o(slc));
  ccp_dev ccp_dev_i (.clk_i, .sys_rst_i, .dev_sel_i(dev_sel_o), .dev_adr_i(dev_adr_o),
    .dev_dat_i(dev_dat_o), .dev_wr_i(dev_wr_o), .pix_lo_i(pix_lo_o), .pix_hi_i(pix_hi_o),
    .pix_stb_i(pix_stb_o), .cas_lo_o(cas_lo_i), .cas_hi_o(cas_hi_i), .cas_valid_o(cas_valid_i));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    report_and_stop();
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // Classic cycle held until the edge that samples ack
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    if (wb_ack_o !== 1'b1) hang();
  endtask
  // Issue a control word, then poll until programming ends
  task automatic start(logic [31:0] c);
    int i = 0;
    bus(1'b1, ADR_CTRL, c);
    do bus(1'b0, ADR_STATUS, 32'h0); while (rd[STAT_BUSY] !== 1'b0 && ++i < 60);
    if (i == 60) hang();
    $display("step %h done", c);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, ADR_GEOM, 32'h0);
    chk("geom", 32'h0011_0000, rd);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, ADR_GEOM, 32'h0000_0200);
    start(32'h1);
    chk("empty grid", 32'h2, rd & 32'h3);
    bus(1'b1, ADR_STATUS, 32'h6);
    bus(1'b1, ADR_GEOM, 32'h0032_0200);
    start(32'h1);
    chk("route0", 16'h0000, ccp_dev_i.regs[0][0] & 16'h0001);
    chk("route1", 16'h0001, ccp_dev_i.regs[1][0] & 16'h0001);
    chk("row", 16'h0207, ccp_dev_i.regs[5][2]);
    chk("align0", 16'h0003, ccp_dev_i.regs[0][3]);
    chk("align1", 16'h0000, ccp_dev_i.regs[1][3]);
    chk("align2", 16'h01FA, ccp_dev_i.regs[2][3]);
    chk("align5", 16'h01F7, ccp_dev_i.regs[5][3]);
    start(32'h9);
    chk("fbk row", 16'h0407, ccp_dev_i.regs[0][1]);
    start(32'h1D);
    chk("lo sign", 16'h0000, ccp_dev_i.regs[0][0] & 16'h0004);
    chk("hi sign", 16'h0004, ccp_dev_i.regs[1][0] & 16'h0004);
    smp_valid_i <= 1'b1;
    n = 0;
    repeat (24) @(posedge clk_i) n += int'(smp_ready_o);
    smp_valid_i <= 1'b0;
    chk("fill", 32'h10, n);
    bus(1'b1, ADR_CTRL, 32'h1E);
    n = 0;
    repeat (200) @(posedge clk_i) if (res_valid_o === 1'b1) begin
      n++;
      chk("result", 32'h2434, res_o);
      chk("slice", 32'h2434, slc);
    end
    chk("drained", 32'h10, n);
    bus(1'b1, ADR_CTRL, 32'hA);
    smp_valid_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    smp_valid_i <= 1'b0;
    n = 0;
    repeat (60) @(posedge clk_i) n += int'(pix_stb_o & bnk & (pix_lo_o == 8'h34));
    chk("feedback", 32'h4, n);
    report_and_stop();
  end
endmodule // ccp_host_bench
